// ==== pixout_pkg.sv ====
// Constants for the receiver pixel output formatter
package pixout_pkg;

	// ==========================================
	// Register map (byte addresses)
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] LINE_COUNT_ADDR = 8'h08;

	// ==========================================
	// Field positions and reset values
	localparam int CTRL_OUT_EN_BIT = 0;
	localparam logic CTRL_OUT_EN_RESET = 1'b1;
	localparam int STATUS_ACTIVE_BIT = 0;
	localparam int STATUS_PIXELS_PER_CLOCK_SELECT_BIT = 1;
	localparam int STATUS_DE_BIT = 2;
	localparam int STATUS_POWERED_BIT = 3;
	localparam int STATUS_ODD_BIT = 4;

	// ==========================================
	// Pixel field positions on both buses
	localparam int BLUE_LSB = 0;
	localparam int GREEN_LSB = 8;
	localparam int RED_LSB = 16;
	localparam int PIXEL_W = 24;
	localparam int COUNT_W = 16;

	// ==========================================
	// Timing counts
	localparam int SYNC_STAGES = 2;
	localparam int ACTIVE_LIMIT = 2048;
	localparam int ACTIVE_W = 12;

endpackage

// ==== pin_sync.sv ====
// Two-flop synchroniser for pins from outside the system clock
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1
) (
	input wire logic i_sys_clk, // System clock
	input wire logic i_rstn, // Synchronous reset, active low
	input wire logic [W-1:0] i_async, // Asynchronous inputs
	output logic [W-1:0] o_sync // Synchronised outputs
);

	logic [W-1:0] meta;
	logic [W-1:0] stable;

	// First stage is read only by the second stage
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			meta <= '0;
			stable <= '0;
		end else begin
			meta <= i_async;
			stable <= meta;
		end
	end

	assign o_sync = stable;

endmodule // pin_sync

// ==== pixel_output_formatter.sv ====
// Pixel output formatter: link pixels onto even/odd buses, power-down, APB
`timescale 1ns/1ns
module pixel_output_formatter (
	input wire logic i_sys_clk, // System clock, 20 MHz
	input wire logic i_rstn, // Synchronous reset, active low
	input wire logic i_link_clk, // Recovered pixel clock of the link
	input wire logic [7:0] i_blue, // Channel 0 pixel data
	input wire logic [7:0] i_green, // Channel 1 pixel data
	input wire logic [7:0] i_red, // Channel 2 pixel data
	input wire logic i_hsync, // Channel 0 blank control
	input wire logic i_vsync, // Channel 0 blank control
	input wire logic [2:0] i_ctl, // Control 3..1 from channels 2 and 1
	input wire logic i_de, // Decoded active display
	input wire logic i_chip_powerdown_n, // Whole chip power-down
	input wire logic i_output_driver_powerdown_n, // Output driver power-down
	input wire logic i_pixels_per_clock_select, // High two pixels per clock
	input wire logic i_stagger_select_n, // Low staggers odd bus
	input wire logic i_output_clock_polarity_select, // High rising edge
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [7:0] i_paddr, // APB address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error
	output logic [23:0] o_even_pixel_bus, // Even pixel bus
	output logic [23:0] o_odd_pixel_bus, // Odd pixel bus
	output logic o_hsync, // Horizontal sync
	output logic o_vsync, // Vertical sync
	output logic o_display_active_flag, // Data enable
	output logic [1:0] o_ctl_upper, // Control 3..2
	output logic o_output_pixel_clock, // Output pixel clock
	output logic o_pixel_oe_n, // Enable of buses, syncs, flag, ctl3..2, clock
	output logic o_general_control_out_1, // Control 1
	output logic o_general_control_out_1_oe_n, // Enable of control 1
	output logic o_link_active_detect, // Link activity
	output logic o_link_active_oe_n // Enable of link activity
);

	// ==========================================
	// Input synchronisation
	localparam int SW = 36;
	logic [SW-1:0] raw_pins;
	logic [SW-1:0] s;

	// All mode pins and link signals come from outside the system clock
	assign raw_pins = {i_link_clk, i_chip_powerdown_n, i_output_driver_powerdown_n,
		i_pixels_per_clock_select, i_stagger_select_n, i_output_clock_polarity_select,
		i_de, i_hsync, i_vsync, i_ctl, i_red, i_green, i_blue};

	pin_sync #(
		.W(SW)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_async(raw_pins),
		.o_sync(s)
	);

	wire lclk_s = s[35];
	wire pd_ok = s[34];
	wire pdo_ok = s[33];
	wire pixels_per_clock_select = s[32];
	wire stagger_select_n_n = s[31];
	wire ock_pol = s[30];
	wire de_s = s[29];
	wire hs_s = s[28];
	wire vs_s = s[27];
	wire [2:0] ctl_s = s[26:24];
	wire [23:0] pix_s = s[23:0];

	// ==========================================
	// State
	logic lclk_d;
	logic [23:0] cap_pix;
	logic [23:0] even_hold;
	logic [23:0] odd_hold;
	logic cap_de;
	logic cap_hs;
	logic cap_vs;
	logic [2:0] cap_ctl;
	logic cap_odd;
	logic upd_d;
	logic stagger_select_n_d;
	logic output_pixel_clock_phase;
	localparam int ACTIVE_W_L = pixout_pkg::ACTIVE_W;
	localparam int CW = pixout_pkg::COUNT_W;
	logic [ACTIVE_W_L-1:0] idle_cnt;
	logic link_active;
	logic [CW-1:0] line_count;
	logic out_en;

	// ==========================================
	// Link clock edges, line start and update events
	wire rise = lclk_s & ~lclk_d & pd_ok;
	wire fall = ~lclk_s & lclk_d & pd_ok;
	wire line_start = rise & de_s & ~cap_de;
	wire next_odd = line_start ? 1'b0 : ~cap_odd;
	wire upd = fall & (~pixels_per_clock_select | cap_odd);
	wire stagger_select_n = pixels_per_clock_select & ~stagger_select_n_n;
	wire [23:0] next_odd_bus = pixels_per_clock_select ? cap_pix : 24'h000000;
	wire [23:0] next_even_bus = pixels_per_clock_select ? even_hold : cap_pix;
	wire odd_load = stagger_select_n ? upd_d & stagger_select_n_d : upd & ~stagger_select_n;
	wire de_change = rise & (de_s != cap_de);
	wire [ACTIVE_W_L-1:0] active_lim = ACTIVE_W_L'(pixout_pkg::ACTIVE_LIMIT - 1);

	// Two-pixel clock high over even pixel, one-pixel clock follows link
	wire next_output_pixel_clock_phase = !pd_ok ? 1'b0 :
		rise ? (pixels_per_clock_select ? ~next_odd : 1'b1) :
		(fall & ~pixels_per_clock_select) ? 1'b0 : output_pixel_clock_phase;

	// Link edge tracking
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			lclk_d <= 1'b0;
		end else begin
			lclk_d <= lclk_s;
		end
	end

	// Capture one pixel with its controls on each link rising edge
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !pd_ok) begin
			cap_pix <= 24'h000000;
			cap_de <= 1'b0;
			cap_hs <= 1'b0;
			cap_vs <= 1'b0;
			cap_ctl <= 3'h0;
			cap_odd <= 1'b1;
		end else if (rise) begin
			cap_pix <= pix_s;
			cap_de <= de_s;
			cap_hs <= hs_s;
			cap_vs <= vs_s;
			cap_ctl <= ctl_s;
			cap_odd <= next_odd;
		end
	end

	// Hold the even pixel until its odd partner arrives
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			even_hold <= 24'h000000;
		end else if (rise & ~next_odd) begin
			even_hold <= pix_s;
		end
	end

	// Pixel count within the current line
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !pd_ok) begin
			line_count <= '0;
		end else if (rise) begin
			line_count <= line_start ? CW'(1) :
				de_s ? line_count + CW'(1) : line_count;
		end
	end

	// ==========================================
	// Output registers, all changing on one output period
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !pd_ok) begin
			o_even_pixel_bus <= 24'h000000;
			o_hsync <= 1'b0;
			o_vsync <= 1'b0;
			o_display_active_flag <= 1'b0;
			o_ctl_upper <= 2'h0;
			o_general_control_out_1 <= 1'b0;
		end else if (upd) begin
			o_even_pixel_bus <= next_even_bus;
			o_hsync <= cap_hs;
			o_vsync <= cap_vs;
			o_display_active_flag <= cap_de;
			o_ctl_upper <= cap_ctl[2:1];
			o_general_control_out_1 <= cap_ctl[0];
		end
	end

	// Odd bus, optionally one system cycle behind the even bus
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !pd_ok) begin
			odd_hold <= 24'h000000;
			o_odd_pixel_bus <= 24'h000000;
			upd_d <= 1'b0;
			stagger_select_n_d <= 1'b0;
		end else begin
			upd_d <= upd;
			stagger_select_n_d <= stagger_select_n;
			if (upd) begin
				odd_hold <= next_odd_bus;
			end
			if (odd_load) begin
				o_odd_pixel_bus <= stagger_select_n ? odd_hold : next_odd_bus;
			end
		end
	end

	// Output clock with selectable latching edge
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			output_pixel_clock_phase <= 1'b0;
			o_output_pixel_clock <= 1'b0;
		end else begin
			output_pixel_clock_phase <= next_output_pixel_clock_phase;
			o_output_pixel_clock <= next_output_pixel_clock_phase ^ ~ock_pol;
		end
	end

	// ==========================================
	// Link activity: data enable must keep toggling
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !pd_ok) begin
			idle_cnt <= '0;
			link_active <= 1'b0;
		end else if (de_change) begin
			idle_cnt <= '0;
			link_active <= 1'b1;
		end else if (rise) begin
			if (idle_cnt == active_lim) begin
				link_active <= 1'b0;
			end else begin
				idle_cnt <= idle_cnt + ACTIVE_W_L'(1);
			end
		end
	end

	// Driver enables, active low
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_pixel_oe_n <= 1'b1;
			o_general_control_out_1_oe_n <= 1'b1;
			o_link_active_oe_n <= 1'b1;
			o_link_active_detect <= 1'b0;
		end else begin
			o_pixel_oe_n <= ~(pd_ok & pdo_ok & out_en);
			o_general_control_out_1_oe_n <= ~pd_ok;
			o_link_active_oe_n <= ~pd_ok;
			o_link_active_detect <= link_active;
		end
	end

	// ==========================================
	// APB slave, one wait state
	wire access = i_psel & i_penable & ~o_pready;
	wire hit_ctrl = i_paddr == pixout_pkg::CTRL_ADDR;
	wire hit_stat = i_paddr == pixout_pkg::STATUS_ADDR;
	wire hit_cnt = i_paddr == pixout_pkg::LINE_COUNT_ADDR;
	wire hit = hit_ctrl | hit_stat | hit_cnt;
	// Write lands at the edge where the master sees ready
	wire wr_ctrl = i_psel & i_penable & o_pready & i_pwrite & hit_ctrl;
	wire [31:0] stat_word = {27'h0000000, cap_odd, pd_ok, cap_de, pixels_per_clock_select, link_active};
	wire [31:0] rd_word = hit_ctrl ? {31'h00000000, out_en} :
		hit_stat ? stat_word :
		hit_cnt ? {16'h0000, line_count} : 32'h00000000;

	// Control register and bus answer
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			out_en <= pixout_pkg::CTRL_OUT_EN_RESET;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
		end else begin
			o_pready <= access;
			o_pslverr <= access & ~hit;
			o_prdata <= (access & ~i_pwrite) ? rd_word : 32'h00000000;
			if (wr_ctrl) begin
				out_en <= i_pwdata[pixout_pkg::CTRL_OUT_EN_BIT];
			end
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	chip_pd_a: assert property (!pd_ok |-> !rise ##1 (o_pixel_oe_n && o_general_control_out_1_oe_n
		&& o_link_active_oe_n && o_even_pixel_bus == 24'h000000))
		else $error("chip power-down left a driver on");
	drv_pd_a: assert property (pd_ok && !pdo_ok |=> o_pixel_oe_n
		&& !o_general_control_out_1_oe_n && !o_link_active_oe_n)
		else $error("driver power-down enables wrong");
	pair_out_a: assert property (upd && pixels_per_clock_select && stagger_select_n_n |=>
		o_odd_pixel_bus == $past(cap_pix) && o_even_pixel_bus == $past(even_hold))
		else $error("pixel pair not presented together");
	one_pix_a: assert property (upd && !pixels_per_clock_select |=> o_even_pixel_bus == $past(cap_pix)
		&& o_even_pixel_bus[7:0] == $past(cap_pix[7:0]))
		else $error("single pixel not on even bus");
	line_even_a: assert property (line_start |=> !cap_odd)
		else $error("line did not start on even pixel");
	odd_low_a: assert property (upd && !pixels_per_clock_select |=> o_odd_pixel_bus == 24'h000000)
		else $error("odd bus not low in one-pixel mode");
	sync_de_a: assert property (upd |=> o_hsync == $past(cap_hs)
		&& o_display_active_flag == $past(cap_de))
		else $error("sync or data enable not routed");
	stagger_a: assert property (upd && stagger_select_n && stagger_select_n_n == 1'b0 |=>
		$stable(o_odd_pixel_bus) ##1 o_odd_pixel_bus == $past(odd_hold))
		else $error("staggered odd bus not one cycle late");
	ock_edge_a: assert property (rise && !pixels_per_clock_select |=> o_output_pixel_clock == $past(ock_pol))
		else $error("output clock polarity wrong");

	two_pix_c: cover property (upd && pixels_per_clock_select && stagger_select_n_n);
	one_pix_c: cover property (upd && !pixels_per_clock_select);
	stagger_select_n_c: cover property (upd && stagger_select_n);
	line_c: cover property (line_start);

endmodule // pixel_output_formatter

// ==== panel_model.sv ====
// Panel model that latches the formatter outputs on its clock
`timescale 1ns/1ns
module panel_model (
	input wire logic i_sys_clk, // Oversampling clock
	input wire logic i_pol, // High latches on rising edge
	input wire logic i_clk, // Output pixel clock
	input wire logic i_oe_n, // Low while outputs driven
	input wire logic [23:0] i_even, // Even pixel bus
	input wire logic [23:0] i_odd, // Odd pixel bus
	input wire logic [2:0] i_ctl, // Hsync, vsync, data enable
	output logic [23:0] o_even, // Latched even pixel
	output logic [23:0] o_odd, // Latched odd pixel
	output logic [2:0] o_ctl // Latched controls
);
	logic prev = 1'b0;

	// ==========
	// Latch only on the edge named by the polarity select
	always @(posedge i_sys_clk) begin
		prev <= i_clk;
		if (!i_oe_n && (i_pol ? (i_clk && !prev) : (!i_clk && prev))) begin
			o_even <= i_even;
			o_odd <= i_odd;
			o_ctl <= i_ctl;
		end
	end
endmodule // panel_model

// ==== test_pixel_output_formatter.sv ====
// Self-checking bench for the pixel output formatter
`timescale 1ns/1ns
module test_pixel_output_formatter;
	logic clk, rstn, lclk, hs, vs, de, pd_n, opd_n, pixels_per_clock_select, stagger_select_n_n, pol, psel, pen, pwr;
	logic pready, pslverr, ohs, ovs, oflag, output_pixel_clock, poe_n, c1, c1oe_n, det, detoe_n, er;
	logic [7:0] blue, green, red, paddr;
	logic [2:0] ctl, lc;
	logic [1:0] cup;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] qe, qo, le, lo;
	logic [23:0] hist[$];
	logic [2:0] chist[$];
	logic [2:0] ctlh[$];
	int fails = 0, num_checks = 0, cyc = 0, k;

	pixel_output_formatter dut (.i_sys_clk(clk), .i_rstn(rstn), .i_link_clk(lclk),
		.i_blue(blue), .i_green(green), .i_red(red), .i_hsync(hs), .i_vsync(vs),
		.i_ctl(ctl), .i_de(de), .i_chip_powerdown_n(pd_n),
		.i_output_driver_powerdown_n(opd_n), .i_pixels_per_clock_select(pixels_per_clock_select),
		.i_stagger_select_n(stagger_select_n_n), .i_output_clock_polarity_select(pol),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_even_pixel_bus(qe), .o_odd_pixel_bus(qo), .o_hsync(ohs), .o_vsync(ovs),
		.o_display_active_flag(oflag), .o_ctl_upper(cup), .o_output_pixel_clock(output_pixel_clock),
		.o_pixel_oe_n(poe_n), .o_general_control_out_1(c1), .o_general_control_out_1_oe_n(c1oe_n),
		.o_link_active_detect(det), .o_link_active_oe_n(detoe_n));

	panel_model panel (.i_sys_clk(clk), .i_pol(pol), .i_clk(output_pixel_clock), .i_oe_n(poe_n),
		.i_even(qe), .i_odd(qo), .i_ctl({ohs, ovs, oflag}), .o_even(le), .o_odd(lo),
		.o_ctl(lc));

	// ==========
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test;
		end
	end

	// ==========
	// Expectation and comparison helpers
	function automatic logic [23:0] pack(input logic [7:0] b, g, r);
		return {r, g, b};
	endfunction

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_pix(input string n, input logic [23:0] e, input logic [23:0] g);
		cmp(n, {8'h00, e}, {8'h00, g});
	endtask

	task stop_test;
		if (fails == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ==========
	// One link pixel of eight cycles; checks what the panel latched before
	task automatic send(input logic d);
		logic [23:0] p;
		logic [2:0] c;
		logic h, v;
		p = pack(8'($urandom), 8'($urandom), 8'($urandom));
		c = 3'($urandom);
		h = d ? hs : 1'($urandom);
		v = d ? vs : 1'($urandom);
		lclk <= 1'b0;
		{red, green, blue} <= p;
		de <= d;
		hs <= h;
		vs <= v;
		ctl <= c;
		hist.push_back(p);
		chist.push_back({h, v, d});
		ctlh.push_back(c);
		repeat (2) @(posedge clk);
		if (!pixels_per_clock_select && k >= 2) begin
			cmp("controls", 32'(chist[k-2]), 32'(lc));
			cmp("ctl", 32'(ctlh[k-2]), 32'({cup, c1}));
			cmp_pix("odd", 24'h000000, lo);
			if (chist[k-2][0]) cmp_pix("even", hist[k-2], le);
		end
		if (pixels_per_clock_select && k >= 3 && k[0] && chist[k-3][0] && chist[k-2][0]) begin
			cmp_pix("even", hist[k-3], le);
			cmp_pix("odd", hist[k-2], lo);
		end
		k++;
		repeat (2) @(posedge clk);
		lclk <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	task automatic run(input logic two, stg, pl);
		pixels_per_clock_select <= two;
		stagger_select_n_n <= stg;
		pol <= pl;
		hist.delete();
		chist.delete();
		ctlh.delete();
		k = 0;
		repeat (2) send(1'b0);
		repeat (10) send(1'b1);
		repeat (2) send(1'b0);
	endtask

	// APB transfer: setup, then access held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pen <= 1'b0;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	// ==========
	// Main sequence
	initial begin
		{rstn, lclk, hs, vs, de, pixels_per_clock_select, psel, pen, pwr} = '0;
		{blue, green, red, paddr, ctl, pwdata} = '0;
		{pd_n, opd_n, stagger_select_n_n, pol} = 4'hf;
		void'($urandom(42));
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, pixout_pkg::CTRL_ADDR, 32'h0);
		cmp("ctrl", 32'(pixout_pkg::CTRL_OUT_EN_RESET), rd);
		apb(1'b0, 8'h0c, 32'h0);
		cmp("pslverr", 32'h1, 32'(er));
		for (int i = 0; i < 8; i++) run(i[2], i[1], i[0]);
		apb(1'b0, pixout_pkg::STATUS_ADDR, 32'h0);
		cmp("pixels_per_clock_select", 32'h1, 32'(rd[pixout_pkg::STATUS_PIXELS_PER_CLOCK_SELECT_BIT]));
		cmp("active", 32'h1, 32'(rd[pixout_pkg::STATUS_ACTIVE_BIT]));
		apb(1'b0, pixout_pkg::LINE_COUNT_ADDR, 32'h0);
		cmp("line count", 32'h0000000a, rd);
		apb(1'b1, pixout_pkg::CTRL_ADDR, 32'h0);
		repeat (3) @(posedge clk);
		cmp("enables", 32'h4, 32'({poe_n, c1oe_n, detoe_n}));
		apb(1'b1, pixout_pkg::CTRL_ADDR, 32'h1);
		opd_n <= 1'b0;
		repeat (5) @(posedge clk);
		cmp("enables", 32'h4, 32'({poe_n, c1oe_n, detoe_n}));
		cmp("detect", 32'h1, 32'(det));
		opd_n <= 1'b1;
		pd_n <= 1'b0;
		repeat (5) @(posedge clk);
		cmp("enables", 32'h7, 32'({poe_n, c1oe_n, detoe_n}));
		pd_n <= 1'b1;
		repeat (6) @(posedge clk);
		cmp("enables", 32'h0, 32'({poe_n, c1oe_n, detoe_n}));
		stop_test;
	end
endmodule // test_pixel_output_formatter
